// [hdl/otp_security_tile.sv]
`timescale 1ns/1ps
module otp_security_tile #(
  parameter logic [3:0] ID_VERSION = 4'h1,      // arbitrary value
  parameter logic [15:0] ID_PART = 16'h0ABC,    // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h123,    // arbitrary value
  parameter logic [otp_sec_pkg::REV_W-1:0] ID_REVISION = 18'h00001, // arbitrary value
  parameter int COPY_ROWS = otp_sec_pkg::DATA_ROWS
) (
  // clock and power-on reset
  input wire logic clk_in,
  input wire logic reset_in,
  // processor i/o ports
  input wire otp_sec_pkg::io_req_t io_req_in,
  output logic [31:0] io_rdata_out,
  output logic io_rvalid_out,
  output logic prog_refused_out,
  // boot copy into sram
  output otp_sec_pkg::sram_wr_t sram_wr_out,
  output logic boot_done_out,
  // security state
  output logic [31:0] security_out,
  output logic link_access_ok_out,
  output logic secure_boot_out,
  output logic redundant_rows_out,
  // jtag pins
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic trst_n_in,
  output logic tdo_out,
  // debug sync pin, open drain
  input wire logic debug_n_in,
  output logic debug_n_out,
  output logic debug_n_oe_out,
  input wire logic dbg_out_mode_in,
  input wire logic dbg_in_mode_in,
  input wire logic breakpoint_in,
  output logic debug_req_out
);

  // ----------------------------------------------------------------
  // pin synchronisers: tck, tms, tdi, trst_n, debug_n
  // ----------------------------------------------------------------
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic tck_prev_r;
  always_ff @(posedge clk_in) begin
    sync1_r <= {debug_n_in, trst_n_in, tdi_in, tms_in, tck_in};
    sync2_r <= sync1_r;
    tck_prev_r <= sync2_r[0];
  end
  wire tck_rise = sync2_r[0] & ~tck_prev_r;
  wire tck_fall = ~sync2_r[0] & tck_prev_r;
  wire tms_s = sync2_r[1];
  wire tdi_s = sync2_r[2];
  wire trst_s = ~sync2_r[3];
  wire debug_low_s = ~sync2_r[4];

  // ----------------------------------------------------------------
  // security register and its decoded permissions
  // ----------------------------------------------------------------
  logic [31:0] sec_r;
  logic loaded_r;
  logic [31:0] mem_rdata;
  // until the load completes every protection is assumed on
  wire [31:0] sec_eff = loaded_r ? sec_r : 32'hFFFF_FFFF;
  wire jtag_otp_ok = ~sec_eff[otp_sec_pkg::SB_NO_JTAG] &
                     ~sec_eff[otp_sec_pkg::SB_NO_JTAG_OTP];
  wire master_lock = sec_eff[otp_sec_pkg::SB_MASTER_LOCK];

  // ----------------------------------------------------------------
  // boot sequence: security row, then copy rows into sram
  // ----------------------------------------------------------------
  otp_sec_pkg::boot_state_t boot_r;
  logic [otp_sec_pkg::ADDR_W-1:0] copy_addr_r;
  logic copy_wr_r;
  logic [otp_sec_pkg::SRAM_AW-1:0] copy_dst_r;
  wire booting = (boot_r != otp_sec_pkg::BOOT_DONE);
  wire copy_last = (32'(copy_addr_r) == COPY_ROWS - 1);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      boot_r <= otp_sec_pkg::BOOT_LOAD;
      copy_addr_r <= '0;
      copy_wr_r <= 1'b0;
      copy_dst_r <= '0;
      loaded_r <= 1'b0;
      sec_r <= otp_sec_pkg::SEC_RESET;
    end else begin
      copy_wr_r <= (boot_r == otp_sec_pkg::BOOT_COPY);
      copy_dst_r <= copy_addr_r[otp_sec_pkg::SRAM_AW-1:0];
      unique case (boot_r)
        otp_sec_pkg::BOOT_LOAD: boot_r <= otp_sec_pkg::BOOT_LATCH;
        otp_sec_pkg::BOOT_LATCH: begin
          sec_r <= mem_rdata;
          loaded_r <= 1'b1;
          boot_r <= otp_sec_pkg::BOOT_COPY;
        end
        otp_sec_pkg::BOOT_COPY: begin
          copy_addr_r <= copy_addr_r + 1'b1;
          if (copy_last) begin
            boot_r <= otp_sec_pkg::BOOT_DONE;
          end
        end
        otp_sec_pkg::BOOT_DONE: boot_r <= otp_sec_pkg::BOOT_DONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // processor i/o port decode
  // ----------------------------------------------------------------
  logic [15:0] io_addr_r;
  logic [31:0] io_data_r;
  logic rd_pend_r;
  wire wr_addr = io_req_in.wr & (io_req_in.res == otp_sec_pkg::RES_ADDR);
  wire wr_data = io_req_in.wr & (io_req_in.res == otp_sec_pkg::RES_DATA);
  wire wr_ctrl = io_req_in.wr & (io_req_in.res == otp_sec_pkg::RES_CTRL) & ~booting;
  wire cpu_prog = wr_ctrl & io_req_in.data[otp_sec_pkg::CTRL_PROG];
  wire cpu_read = wr_ctrl & io_req_in.data[otp_sec_pkg::CTRL_READ];

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      io_addr_r <= '0;
      io_data_r <= '0;
      rd_pend_r <= 1'b0;
    end else begin
      if (wr_addr) begin
        io_addr_r <= io_req_in.data[15:0];
      end
      if (wr_data) begin
        io_data_r <= io_req_in.data;
      end
      rd_pend_r <= cpu_read & ~cpu_prog;
    end
  end

  // ----------------------------------------------------------------
  // jtag tap pair sharing tms/tck; tap0 nearest tdo holds otp access
  // ----------------------------------------------------------------
  otp_sec_pkg::tap_state_t tap_r;
  otp_sec_pkg::tap_state_t tap_nxt;
  logic [7:0] ir_sh_r;
  logic [7:0] ir_r;
  logic [63:0] dr_r;
  logic [otp_sec_pkg::ADDR_W-1:0] jtag_addr_r;

  always_comb begin
    unique case (tap_r)
      otp_sec_pkg::TAP_RESET: tap_nxt = tms_s ? otp_sec_pkg::TAP_RESET : otp_sec_pkg::TAP_IDLE;
      otp_sec_pkg::TAP_IDLE: tap_nxt = tms_s ? otp_sec_pkg::TAP_SEL_DR : otp_sec_pkg::TAP_IDLE;
      otp_sec_pkg::TAP_SEL_DR: tap_nxt = tms_s ? otp_sec_pkg::TAP_SEL_IR : otp_sec_pkg::TAP_CAP_DR;
      otp_sec_pkg::TAP_CAP_DR: tap_nxt = tms_s ? otp_sec_pkg::TAP_EX1_DR : otp_sec_pkg::TAP_SH_DR;
      otp_sec_pkg::TAP_SH_DR: tap_nxt = tms_s ? otp_sec_pkg::TAP_EX1_DR : otp_sec_pkg::TAP_SH_DR;
      otp_sec_pkg::TAP_EX1_DR: tap_nxt = tms_s ? otp_sec_pkg::TAP_UPD_DR : otp_sec_pkg::TAP_PA_DR;
      otp_sec_pkg::TAP_PA_DR: tap_nxt = tms_s ? otp_sec_pkg::TAP_EX2_DR : otp_sec_pkg::TAP_PA_DR;
      otp_sec_pkg::TAP_EX2_DR: tap_nxt = tms_s ? otp_sec_pkg::TAP_UPD_DR : otp_sec_pkg::TAP_SH_DR;
      otp_sec_pkg::TAP_UPD_DR: tap_nxt = tms_s ? otp_sec_pkg::TAP_SEL_DR : otp_sec_pkg::TAP_IDLE;
      otp_sec_pkg::TAP_SEL_IR: tap_nxt = tms_s ? otp_sec_pkg::TAP_RESET : otp_sec_pkg::TAP_CAP_IR;
      otp_sec_pkg::TAP_CAP_IR: tap_nxt = tms_s ? otp_sec_pkg::TAP_EX1_IR : otp_sec_pkg::TAP_SH_IR;
      otp_sec_pkg::TAP_SH_IR: tap_nxt = tms_s ? otp_sec_pkg::TAP_EX1_IR : otp_sec_pkg::TAP_SH_IR;
      otp_sec_pkg::TAP_EX1_IR: tap_nxt = tms_s ? otp_sec_pkg::TAP_UPD_IR : otp_sec_pkg::TAP_PA_IR;
      otp_sec_pkg::TAP_PA_IR: tap_nxt = tms_s ? otp_sec_pkg::TAP_EX2_IR : otp_sec_pkg::TAP_PA_IR;
      otp_sec_pkg::TAP_EX2_IR: tap_nxt = tms_s ? otp_sec_pkg::TAP_UPD_IR : otp_sec_pkg::TAP_SH_IR;
      otp_sec_pkg::TAP_UPD_IR: tap_nxt = tms_s ? otp_sec_pkg::TAP_SEL_DR : otp_sec_pkg::TAP_IDLE;
    endcase
  end

  // identification words offered on capture
  wire [31:0] jtag_identification_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  wire [31:0] usercode = {sec_eff[31:otp_sec_pkg::SB_USER_ID_LSB] & {10{loaded_r}},
                          {otp_sec_pkg::UNUSED_W{1'b0}}, ID_REVISION};
  wire [3:0] ir0 = ir_r[3:0];
  wire [3:0] ir1 = ir_r[7:4];
  wire [31:0] cap0 = (ir0 == otp_sec_pkg::IR_JTAG_IDENTIFICATION_WORD) ? jtag_identification_word :
                     (ir0 == otp_sec_pkg::IR_USERCODE) ? usercode :
                     (ir0 == otp_sec_pkg::IR_OTP_READ && jtag_otp_ok) ? mem_rdata :
                     32'h0000_0000;
  wire [31:0] cap1 = (ir1 == otp_sec_pkg::IR_JTAG_IDENTIFICATION_WORD) ? jtag_identification_word :
                     (ir1 == otp_sec_pkg::IR_USERCODE) ? usercode : 32'h0000_0000;
  wire upd_dr = tck_rise & (tap_r == otp_sec_pkg::TAP_UPD_DR);
  wire jtag_prog = upd_dr & (ir0 == otp_sec_pkg::IR_OTP_WRITE) & jtag_otp_ok &
                   ~booting & ~cpu_prog;

  // tap registers advance on each synchronised tck rise
  always_ff @(posedge clk_in) begin
    if (reset_in || trst_s) begin
      tap_r <= otp_sec_pkg::TAP_RESET;
      ir_sh_r <= '0;
      ir_r <= {otp_sec_pkg::IR_JTAG_IDENTIFICATION_WORD, otp_sec_pkg::IR_JTAG_IDENTIFICATION_WORD};
      dr_r <= '0;
      jtag_addr_r <= '0;
    end else if (tck_rise) begin
      tap_r <= tap_nxt;
      unique case (tap_r)
        otp_sec_pkg::TAP_RESET: ir_r <= {otp_sec_pkg::IR_JTAG_IDENTIFICATION_WORD, otp_sec_pkg::IR_JTAG_IDENTIFICATION_WORD};
        otp_sec_pkg::TAP_CAP_IR: ir_sh_r <= otp_sec_pkg::IR_CAPTURE;
        otp_sec_pkg::TAP_SH_IR: ir_sh_r <= {tdi_s, ir_sh_r[7:1]};
        otp_sec_pkg::TAP_UPD_IR: ir_r <= ir_sh_r;
        otp_sec_pkg::TAP_CAP_DR: dr_r <= {cap1, cap0};
        otp_sec_pkg::TAP_SH_DR: dr_r <= {tdi_s, dr_r[63:1]};
        otp_sec_pkg::TAP_UPD_DR: begin
          if (ir0 == otp_sec_pkg::IR_OTP_ADDR && jtag_otp_ok) begin
            jtag_addr_r <= dr_r[otp_sec_pkg::ADDR_W-1:0];
          end
        end
        default: ir_r <= ir_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // otp array access and lock checks
  // ----------------------------------------------------------------
  wire [otp_sec_pkg::ADDR_W-1:0] prog_addr = cpu_prog ? io_addr_r[otp_sec_pkg::ADDR_W-1:0]
                                                      : jtag_addr_r;
  wire [31:0] prog_data = cpu_prog ? io_data_r : dr_r[31:0];
  wire [1:0] prog_sector = prog_addr[10:9];
  wire prog_is_sec = (prog_addr == otp_sec_pkg::SEC_ROW);
  wire prog_in_data = ~prog_addr[11];
  wire sector_locked = sec_eff[otp_sec_pkg::SB_SECTOR_LOCK0 + 32'(prog_sector)];
  wire prog_req = cpu_prog | jtag_prog;
  wire prog_ok = ~master_lock & (prog_is_sec | (prog_in_data & ~sector_locked));
  wire mem_we = prog_req & prog_ok & ~booting;
  wire [otp_sec_pkg::ADDR_W-1:0] mem_addr =
    (boot_r == otp_sec_pkg::BOOT_LOAD) ? otp_sec_pkg::SEC_ROW :
    booting ? copy_addr_r :
    prog_req ? prog_addr :
    cpu_read ? io_addr_r[otp_sec_pkg::ADDR_W-1:0] : jtag_addr_r;

  otp_array #(
    .DEPTH(otp_sec_pkg::DATA_ROWS + 1),
    .AW(otp_sec_pkg::ADDR_W)
  ) u_array (
    .clk_in(clk_in),
    .we_in(mem_we),
    .addr_in(mem_addr),
    .wdata_in(prog_data),
    .rdata_out(mem_rdata)
  );

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      io_rdata_out <= '0;
      io_rvalid_out <= 1'b0;
      prog_refused_out <= 1'b0;
      sram_wr_out <= '0;
      boot_done_out <= 1'b0;
      security_out <= otp_sec_pkg::SEC_RESET;
      link_access_ok_out <= 1'b0;
      secure_boot_out <= 1'b0;
      redundant_rows_out <= 1'b0;
    end else begin
      io_rvalid_out <= rd_pend_r;
      if (rd_pend_r) begin
        io_rdata_out <= mem_rdata;
      end
      prog_refused_out <= prog_req & ~prog_ok;
      sram_wr_out.we <= copy_wr_r;
      sram_wr_out.be <= 4'hF;
      sram_wr_out.addr <= copy_dst_r;
      sram_wr_out.data <= mem_rdata;
      boot_done_out <= ~booting & ~copy_wr_r;
      security_out <= sec_r;
      link_access_ok_out <= ~sec_eff[otp_sec_pkg::SB_NO_LINK];
      secure_boot_out <= loaded_r & sec_r[otp_sec_pkg::SB_SECURE_BOOT];
      redundant_rows_out <= loaded_r & sec_r[otp_sec_pkg::SB_REDUNDANT];
    end
  end

  // tdo changes on the falling tck; shut off entirely when jtag is disabled
  always_ff @(posedge clk_in) begin
    if (reset_in || trst_s) begin
      tdo_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out <= ~sec_eff[otp_sec_pkg::SB_NO_JTAG] &
                 ((tap_r == otp_sec_pkg::TAP_SH_IR) ? ir_sh_r[0] : dr_r[0]);
    end
  end

  // ----------------------------------------------------------------
  // debug sync pin: open drain, only ever pulls low
  // ----------------------------------------------------------------
  wire dbg_allowed = ~sec_eff[otp_sec_pkg::SB_NO_DEBUG_PIN];
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      debug_n_out <= 1'b0;
      debug_n_oe_out <= 1'b0;
      debug_req_out <= 1'b0;
    end else begin
      debug_n_out <= 1'b0;
      debug_n_oe_out <= dbg_allowed & dbg_out_mode_in & breakpoint_in;
      debug_req_out <= dbg_allowed & dbg_in_mode_in & debug_low_s;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_load_first;
    @(posedge clk_in) disable iff (reset_in)
    $rose(loaded_r) |-> $past(boot_r) == otp_sec_pkg::BOOT_LATCH;
  endproperty
  a_load_first: assert property (p_load_first) else $error("security loaded out of order");

  property p_no_prog_booting;
    @(posedge clk_in) disable iff (reset_in)
    booting |-> !mem_we;
  endproperty
  a_no_prog_booting: assert property (p_no_prog_booting) else $error("write during boot");

  property p_master_lock;
    @(posedge clk_in) disable iff (reset_in)
    (loaded_r && sec_r[otp_sec_pkg::SB_MASTER_LOCK] && prog_req) |-> ##1 prog_refused_out;
  endproperty
  a_master_lock: assert property (p_master_lock) else $error("master lock ignored");

  property p_sector_lock;
    @(posedge clk_in) disable iff (reset_in)
    (mem_we && prog_in_data) |-> !sec_r[otp_sec_pkg::SB_SECTOR_LOCK0 + 32'(prog_sector)];
  endproperty
  a_sector_lock: assert property (p_sector_lock) else $error("locked sector written");

  property p_link;
    @(posedge clk_in) disable iff (reset_in)
    loaded_r ##1 loaded_r |-> link_access_ok_out == !$past(sec_r[otp_sec_pkg::SB_NO_LINK]);
  endproperty
  a_link: assert property (p_link) else $error("link access mismatch");

  property p_jtag_otp;
    @(posedge clk_in) disable iff (reset_in)
    (sec_eff[otp_sec_pkg::SB_NO_JTAG_OTP] || sec_eff[otp_sec_pkg::SB_NO_JTAG]) |-> !jtag_prog;
  endproperty
  a_jtag_otp: assert property (p_jtag_otp) else $error("jtag otp access while denied");

  property p_debug_oe;
    @(posedge clk_in) disable iff (reset_in)
    debug_n_oe_out |-> $past(breakpoint_in && dbg_out_mode_in) && !debug_n_out;
  endproperty
  a_debug_oe: assert property (p_debug_oe) else $error("debug pin driven wrongly");

  property p_copy_done;
    @(posedge clk_in) disable iff (reset_in)
    $rose(boot_done_out) |-> $past(sram_wr_out.we, 2) && !sram_wr_out.we;
  endproperty
  a_copy_done: assert property (p_copy_done) else $error("boot done before copy");

endmodule

// [pkg/otp_sec_pkg.sv]
// Operation
// - otp store is four sectors of 512 rows, 32 bits each, 8 KB
// - security register loads from otp at power-up before its bits take effect
// - remaining otp contents are copied to sram before the processor runs
// - otp program address arrives on 16-bit port resource 0x100200
// - otp program data arrives on 32-bit port resource 0x200100
// - otp program control arrives on 16-bit port resource 0x100300
// - security bit 0 shuts jtag out of tile state and memory
// - security bit 1 refuses other tiles access through the switch
// - security bit 5 boots the tile from otp address 0
// - security bit 7 enables redundant otp rows
// - security bits 8 to 11 lock programming of sectors 0 to 3
// - security bit 12 blocks every otp update including security row
// - security bit 13 denies jtag read and write of otp
// - security bit 14 disables the debug sync pin entirely
// - security bits 31 to 22 extend the jtag usercode
// - sram is 32 bits wide, byte half word accesses in one cycle
// - jtag chain has two taps, each 4-bit ir and 32-bit dr
// - output mode: debug pin floats, driven low at a breakpoint
// - input mode: debug pin pulled low puts tile into debug mode
// - jtag_identification_word returns version, part number and manufacturer fields
// - usercode holds tile 0 security bits 31 to 22, unused and revision
package otp_sec_pkg;

  // ----------------------------------------------------------------
  // otp geometry
  // ----------------------------------------------------------------
  localparam int SECTORS = 4;
  localparam int ROWS_PER_SECTOR = 512;
  localparam int ROW_BITS = 32;
  localparam int DATA_ROWS = SECTORS * ROWS_PER_SECTOR;
  localparam int ADDR_W = 12;
  localparam int SRAM_AW = 11;
  localparam logic [11:0] SEC_ROW = 12'h800;

  // ----------------------------------------------------------------
  // i/o port resource numbers and control bits
  // ----------------------------------------------------------------
  localparam logic [23:0] RES_ADDR = 24'h100200;
  localparam logic [23:0] RES_DATA = 24'h200100;
  localparam logic [23:0] RES_CTRL = 24'h100300;
  localparam int CTRL_PROG = 0;
  localparam int CTRL_READ = 1;

  // ----------------------------------------------------------------
  // security register bit positions and reset value
  // ----------------------------------------------------------------
  localparam int SB_NO_JTAG = 0;
  localparam int SB_NO_LINK = 1;
  localparam int SB_SECURE_BOOT = 5;
  localparam int SB_REDUNDANT = 7;
  localparam int SB_SECTOR_LOCK0 = 8;
  localparam int SB_MASTER_LOCK = 12;
  localparam int SB_NO_JTAG_OTP = 13;
  localparam int SB_NO_DEBUG_PIN = 14;
  localparam int SB_USER_ID_LSB = 22;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // jtag instructions and identification layout
  // ----------------------------------------------------------------
  localparam logic [3:0] IR_JTAG_IDENTIFICATION_WORD = 4'h1;
  localparam logic [3:0] IR_USERCODE = 4'h2;
  localparam logic [3:0] IR_OTP_ADDR = 4'h3;
  localparam logic [3:0] IR_OTP_READ = 4'h4;
  localparam logic [3:0] IR_OTP_WRITE = 4'h5;
  localparam logic [7:0] IR_CAPTURE = 8'h11;
  localparam int UNUSED_W = 4;
  localparam int REV_W = 18;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [23:0] res;
    logic [31:0] data;
  } io_req_t;

  typedef struct packed {
    logic we;
    logic [3:0] be;
    logic [SRAM_AW-1:0] addr;
    logic [31:0] data;
  } sram_wr_t;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef enum logic [1:0] {BOOT_LOAD, BOOT_LATCH, BOOT_COPY, BOOT_DONE} boot_state_t;

endpackage

// [hdl/otp_array.sv]
`timescale 1ns/1ps
// otp cell array: a write can only set bits, so old contents are or-ed in
module otp_array #(
  parameter int DEPTH = 2049,
  parameter int AW = 12
) (
  // clock
  input wire logic clk_in,
  // access
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out
);

  // unprogrammed fuses read as zero, and the contents outlive every reset
  logic [31:0] mem [DEPTH] = '{default: 32'h0000_0000};

  // ----------------------------------------------------------------
  // registered read, fuse-style write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (we_in && (32'(addr_in) < DEPTH)) begin
      mem[addr_in] <= mem[addr_in] | wdata_in;
    end
    rdata_out <= (32'(addr_in) < DEPTH) ? mem[addr_in] : 32'h0000_0000;
  end

endmodule

// [tb/jtag_host.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// jtag host model: tck idles low between frames, tdi idles high
// ----------------------------------------------------------------
module jtag_host (
  // jtag pins
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trst_n_out,
  input wire logic tdo_in
);
  // test reset is low from power-up on
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    trst_n_out = 1'b0;
  end

  // one tck period, 6 clk each phase; tdo is sampled just before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #48;
    tdo = tdo_in;
    tck_out = 1'b1;
    #48;
    tck_out = 1'b0;
  endtask

  // held low well past 100 ns, then one tick moves the tap to idle
  task automatic trst_pulse();
    logic b;
    trst_n_out = 1'b0;
    #200;
    trst_n_out = 1'b1;
    tick(1'b0, 1'b1, b);
  endtask

  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, 1'b1, b);
    if (ir) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask
endmodule

// [tb/otp_security_jtag_id_tb.sv]
`timescale 1ns/1ps
module otp_security_jtag_id_tb;
  localparam logic [3:0] VER = 4'h2; // arbitrary value
  localparam logic [15:0] PART = 16'h1357; // arbitrary value
  localparam logic [10:0] MAKER = 11'h2A5; // arbitrary value
  localparam logic [17:0] REV = 18'h00042; // arbitrary value
  localparam logic [31:0] SEC1 = 32'hA5C0_02A2;
  localparam logic [31:0] SEC2 = 32'h0000_7001;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  otp_sec_pkg::io_req_t io_req_in = '0;
  otp_sec_pkg::sram_wr_t sram_wr;
  logic [31:0] io_rdata, security, d;
  logic rvalid, refused_p, done, link_ok, sboot, redund, tck, tms, tdi, trst_n, tdo;
  logic dbg_n, dbg_oe, dbg_req, r;
  logic out_mode = 1'b0;
  logic in_mode = 1'b0;
  logic bkpt = 1'b0;
  logic ext_low = 1'b0;
  int errors = 0;
  int check_count = 0;
  int writes = 0;
  logic [31:0] copy_row5 = 32'h0000_0000;
  wire dbg_pin = dbg_oe ? dbg_n : (ext_low ? 1'b0 : 1'b1); // pulled up

  initial forever #4 clk_in = ~clk_in;
  // count full-word copy writes into sram during boot
  // and keep the word copied into sram word 5 for a data check
  always @(posedge clk_in) begin
    if (sram_wr.we === 1'b1 && sram_wr.be === 4'hF) writes++;
    if (sram_wr.we === 1'b1 && sram_wr.addr === 11'h005) copy_row5 = sram_wr.data;
  end

  otp_security_tile #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
    .ID_REVISION(REV), .COPY_ROWS(8)) DUT (.clk_in(clk_in), .reset_in(reset_in),
    .io_req_in(io_req_in), .io_rdata_out(io_rdata), .io_rvalid_out(rvalid),
    .prog_refused_out(refused_p), .sram_wr_out(sram_wr), .boot_done_out(done),
    .security_out(security), .link_access_ok_out(link_ok), .secure_boot_out(sboot),
    .redundant_rows_out(redund), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .trst_n_in(trst_n), .tdo_out(tdo), .debug_n_in(dbg_pin), .debug_n_out(dbg_n),
    .debug_n_oe_out(dbg_oe), .dbg_out_mode_in(out_mode), .dbg_in_mode_in(in_mode),
    .breakpoint_in(bkpt), .debug_req_out(dbg_req));
  jtag_host u_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n),
    .tdo_in(tdo));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask
  task automatic io_wr(input logic [23:0] res, input logic [31:0] data);
    @(posedge clk_in);
    io_req_in <= '{wr: 1'b1, res: res, data: data};
  endtask
  // address, data, control back to back; any refusal pulse in 3 cycles counts
  task automatic prog(input logic [11:0] a, input logic [31:0] v, output logic refused);
    io_wr(otp_sec_pkg::RES_ADDR, {20'h0, a});
    io_wr(otp_sec_pkg::RES_DATA, v);
    io_wr(otp_sec_pkg::RES_CTRL, 32'h1);
    refused = 1'b0;
    repeat (3) begin
      @(posedge clk_in);
      io_req_in.wr <= 1'b0;
      #1 refused |= refused_p;
    end
  endtask
  // read answer is one pulse; an absent answer leaves x and mismatches
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    io_wr(otp_sec_pkg::RES_ADDR, {20'h0, a});
    io_wr(otp_sec_pkg::RES_CTRL, 32'h2);
    v = 'x;
    repeat (4) begin
      @(posedge clk_in);
      io_req_in.wr <= 1'b0;
      #1 if (rvalid === 1'b1) v = io_rdata;
    end
  endtask
  // power-on reset, then bounded wait for load and copy
  task automatic boot();
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    #1 chk("security in reset", 32'h0, security);
    writes = 0;
    @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge clk_in);
    if (done !== 1'b1) begin
      errors++;
      stop_test();
    end
    chk("copy writes", 32'd8, 32'(writes));
    u_host.trst_pulse();
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    boot();
    chk("link boot redundant", 32'h4, {link_ok, sboot, redund});
    prog(12'h005, 32'h0000_00F0, r);
    prog(12'h005, 32'h0000_0F00, r);
    chk("refused", 32'h0, r);
    rd(12'h005, d);
    chk("otp row", 32'h0000_0FF0, d);
    u_host.scan(1'b0, 32, 32'h0, d);
    chk("jtag_identification_word", {VER, PART, MAKER, 1'b1}, d);
    @(posedge clk_in);
    out_mode <= 1'b1;
    bkpt <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("debug pin drive", 32'h1, dbg_oe);
    out_mode <= 1'b0;
    bkpt <= 1'b0;
    in_mode <= 1'b1;
    ext_low <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk("debug request", 32'h1, dbg_req);
    in_mode <= 1'b0;
    ext_low <= 1'b0;
    $display("test plain boot done");
    prog(otp_sec_pkg::SEC_ROW, SEC1, r);
    boot();
    chk("security", SEC1, security);
    chk("copied row", 32'h0000_0FF0, copy_row5);
    chk("link boot redundant", 32'h3, {link_ok, sboot, redund});
    u_host.scan(1'b1, 8, 32'h22, d);
    u_host.scan(1'b0, 32, 32'h0, d);
    chk("usercode", {SEC1[31:22], 4'h0, REV}, d);
    prog(12'h200, 32'h1, r);
    chk("locked sector refused", 32'h1, r);
    rd(12'h200, d);
    chk("locked row", 32'h0, d);
    prog(12'h1FF, 32'h3, r);
    chk("open sector refused", 32'h0, r);
    rd(12'h1FF, d);
    chk("open row", 32'h3, d);
    $display("test sector lock done");
    prog(otp_sec_pkg::SEC_ROW, SEC2, r);
    boot();
    chk("security", SEC1 | SEC2, security);
    prog(12'h005, 32'h0000_1000, r);
    chk("master lock refused", 32'h1, r);
    rd(12'h005, d);
    chk("master locked row", 32'h0000_0FF0, d);
    u_host.scan(1'b0, 32, 32'h0, d);
    chk("jtag disabled", 32'h0, d);
    @(posedge clk_in);
    out_mode <= 1'b1;
    bkpt <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("debug pin disabled", 32'h0, dbg_oe);
    $display("test master lock done");
    stop_test();
  end
endmodule
